// [verilog/sfr_pkg.sv]
package sfr_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_READ_FAST = 8'h0B;
  localparam logic [7:0] OP_READ_DUAL = 8'h3B;
  localparam logic [7:0] OP_READ_QUAD = 8'h6B;
  // ----------------------------------------------------------------
  // Array geometry and frame lengths in serial clocks
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam logic [23:0] ARRAY_TOP = 24'h07FFFF;
  localparam logic [23:0] ARRAY_BASE = 24'h000000;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] DUMMY_BITS = 6'h08;
  // ----------------------------------------------------------------
  // Host serial clock divider: half period in core clocks, minus one
  // ----------------------------------------------------------------
  localparam logic [3:0] SCK_HALF = 4'h2;
  // Lane count per read kind
  typedef enum logic [1:0] {
    SFR_LANE_ONE,
    SFR_LANE_TWO,
    SFR_LANE_FOUR
  } sfr_lane_t;
endpackage : sfr_pkg

// [verilog/sfr_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Four serial lanes plus select and clock; each lane is out, enable and in
interface sfr_if;
  logic csN;
  logic sck;
  logic [3:0] hostOut;
  logic [3:0] hostOe;
  logic [3:0] devOut;
  logic [3:0] devOe;
  // Resolved lane levels; an undriven lane is pulled high
  logic [3:0] lane;
  assign lane = (hostOe & hostOut) | (devOe & devOut) | ~(hostOe | devOe);
  // Lane 0 serial in, 1 serial out, 2 write protect io, 3 pause io line
  modport dev (input csN, input sck, input lane, output devOut, output devOe);
  modport host (output csN, output sck, output hostOut, output hostOe, input lane);
endinterface : sfr_if
`default_nettype wire

// [verilog/sfr_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host controller: one read per start pulse, bytes out as one-cycle strobes
module sfr_host (
  input wire logic core_clk,
  input wire logic resetn,
  sfr_if.host bus,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [23:0] startAddr,
  input wire logic stop,
  output logic busy,
  output logic byteValid,
  output logic [7:0] byteData
);
  typedef enum logic [1:0] {SFR_H_IDLE, SFR_H_SEND, SFR_H_DATA} sfr_hstate_t;
  sfr_hstate_t state_r;
  logic [3:0] divCnt_r;
  logic sck_r;
  logic [39:0] shift_r;
  logic [5:0] bitCnt_r;
  logic [5:0] sendLen_r;
  sfr_pkg::sfr_lane_t lanes_r;
  logic [7:0] rx_r;
  logic [2:0] rxCnt_r;
  logic rise;
  logic fall;
  logic [2:0] lastCnt;
  logic [7:0] rxNxt;

  assign rise = (state_r != SFR_H_IDLE) && (divCnt_r == sfr_pkg::SCK_HALF) && !sck_r;
  assign fall = (state_r != SFR_H_IDLE) && (divCnt_r == sfr_pkg::SCK_HALF) && sck_r;
  assign busy = (state_r != SFR_H_IDLE);
  assign bus.csN = (state_r == SFR_H_IDLE);
  assign bus.sck = sck_r;
  // Host drives serial in only while sending opcode, address, dummy
  assign bus.hostOe = {3'h0, state_r == SFR_H_SEND};
  assign bus.hostOut = {3'h0, shift_r[39]};
  // Clocks per byte minus one, per lane count
  assign lastCnt = (lanes_r == sfr_pkg::SFR_LANE_FOUR) ? 3'h1 :
                   (lanes_r == sfr_pkg::SFR_LANE_TWO) ? 3'h3 : 3'h7;
  always_comb begin
    unique case (lanes_r)
      sfr_pkg::SFR_LANE_FOUR: rxNxt = {rx_r[3:0], bus.lane[3], bus.lane[2], bus.lane[1],
                                       bus.lane[0]};
      sfr_pkg::SFR_LANE_TWO: rxNxt = {rx_r[5:0], bus.lane[1], bus.lane[0]};
      default: rxNxt = {rx_r[6:0], bus.lane[1]};
    endcase
  end

  // Clock divider; sck idles low (mode 0); one rate low enough for every opcode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 4'h0;
      sck_r <= 1'b0;
    end else if (state_r == SFR_H_IDLE) begin
      divCnt_r <= 4'h0;
      sck_r <= 1'b0;
    end else if (divCnt_r == sfr_pkg::SCK_HALF) begin
      divCnt_r <= 4'h0;
      sck_r <= !sck_r;
    end else begin
      divCnt_r <= divCnt_r + 4'h1;
    end
  end

  // Sequencing: bits change after falling edges, sampled on rising
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SFR_H_IDLE;
      shift_r <= 40'h0;
      bitCnt_r <= 6'h0;
      sendLen_r <= 6'h0;
      lanes_r <= sfr_pkg::SFR_LANE_ONE;
    end else begin
      unique case (state_r)
        SFR_H_IDLE: begin
          if (start) begin
            state_r <= SFR_H_SEND;
            shift_r <= {opcode, startAddr, 8'h00};  // MSB first, A23 leads
            bitCnt_r <= 6'h0;
            // Slow read skips the dummy byte; others send one
            sendLen_r <= (opcode == sfr_pkg::OP_READ_SLOW) ?
                         sfr_pkg::CMD_BITS + sfr_pkg::ADDR_BITS :
                         sfr_pkg::CMD_BITS + sfr_pkg::ADDR_BITS + sfr_pkg::DUMMY_BITS;
            lanes_r <= (opcode == sfr_pkg::OP_READ_QUAD) ? sfr_pkg::SFR_LANE_FOUR :
                       (opcode == sfr_pkg::OP_READ_DUAL) ? sfr_pkg::SFR_LANE_TWO :
                       sfr_pkg::SFR_LANE_ONE;
          end
        end
        SFR_H_SEND: begin
          if (stop) begin
            state_r <= SFR_H_IDLE;
          end else if (fall) begin
            shift_r <= {shift_r[38:0], 1'b0};
            bitCnt_r <= bitCnt_r + 6'h1;
            if (bitCnt_r + 6'h1 == sendLen_r) begin
              state_r <= SFR_H_DATA;
            end
          end
        end
        SFR_H_DATA: begin
          if (stop) begin
            state_r <= SFR_H_IDLE;  // Any clock, even mid-byte
          end
        end
        default: state_r <= SFR_H_IDLE;
      endcase
    end
  end

  // Data capture on rising edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_r <= 8'h00;
      rxCnt_r <= 3'h0;
      byteValid <= 1'b0;
      byteData <= 8'h00;
    end else begin
      byteValid <= 1'b0;
      if (state_r != SFR_H_DATA) begin
        rxCnt_r <= 3'h0;
      end else if (rise) begin
        rx_r <= rxNxt;
        if (rxCnt_r == lastCnt) begin
          rxCnt_r <= 3'h0;
          byteValid <= 1'b1;
          byteData <= rxNxt;
        end else begin
          rxCnt_r <= rxCnt_r + 3'h1;
        end
      end
    end
  end
endmodule : sfr_host
`default_nettype wire

// [verilog/sfr_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module sfr_dev (
  input wire logic core_clk,
  input wire logic resetn,
  sfr_if.dev bus,
  input wire logic quadEnable,
  output logic [23:0] memAddr,
  input wire logic [7:0] memData,
  output logic reading
);
  typedef enum logic [1:0] {SFR_D_CMD, SFR_D_ADDR, SFR_D_DUMMY, SFR_D_DATA} sfr_dstate_t;
  sfr_dstate_t state_r;
  logic sckD_r;
  logic [5:0] bitCnt_r;
  logic [7:0] op_r;
  logic [23:0] addr_r;
  sfr_pkg::sfr_lane_t lanes_r;
  logic valid_r;
  logic [7:0] outByte_r;
  logic [2:0] slot_r;
  logic [3:0] out_r;
  logic [3:0] oe_r;
  logic rise;
  logic fall;
  logic [7:0] opNxt;
  logic [2:0] lastSlot;

  // ----------------------------------------------------------------
  // Edge strobes and lane drive
  // ----------------------------------------------------------------
  // Sck and select are treated as synchronous inputs at core rate
  assign rise = !bus.csN && bus.sck && !sckD_r;
  assign fall = !bus.csN && !bus.sck && sckD_r;
  assign opNxt = {op_r[6:0], bus.lane[0]};
  assign memAddr = addr_r;
  assign reading = (state_r == SFR_D_DATA);
  // Select high forces every lane off at once
  assign bus.devOut = out_r;
  assign bus.devOe = bus.csN ? 4'h0 : oe_r;
  assign lastSlot = (lanes_r == sfr_pkg::SFR_LANE_FOUR) ? 3'h1 :
                    (lanes_r == sfr_pkg::SFR_LANE_TWO) ? 3'h3 : 3'h7;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Next address with wrap at the top of the array
  function automatic logic [23:0] sfr_next_addr(input logic [23:0] a);
    sfr_next_addr = (a == sfr_pkg::ARRAY_TOP) ? sfr_pkg::ARRAY_BASE : a + 24'h1;
  endfunction : sfr_next_addr

  // Lane bits for one slot of a byte
  function automatic logic [3:0] sfr_slot_bits(input sfr_pkg::sfr_lane_t ln,
                                               input logic [7:0] b, input logic [2:0] s);
    logic [2:0] idx;
    idx = 3'h7 - s;
    unique case (ln)
      sfr_pkg::SFR_LANE_FOUR: sfr_slot_bits = s[0] ? {b[3], b[2], b[1], b[0]} :
                                                     {b[7], b[6], b[5], b[4]};
      sfr_pkg::SFR_LANE_TWO: sfr_slot_bits = {2'h0, b[3'h7 - {s[1:0], 1'b0}],
                                               b[3'h6 - {s[1:0], 1'b0}]};
      default: sfr_slot_bits = {2'h0, b[idx], 1'b0};
    endcase
  endfunction : sfr_slot_bits

  // Lanes the device owns once data starts; the host has let go of them by then
  function automatic logic [3:0] sfr_lane_oe(input sfr_pkg::sfr_lane_t ln);
    unique case (ln)
      sfr_pkg::SFR_LANE_FOUR: sfr_lane_oe = 4'hF;
      sfr_pkg::SFR_LANE_TWO: sfr_lane_oe = 4'h3;
      default: sfr_lane_oe = 4'h2;
    endcase
  endfunction : sfr_lane_oe

  // ----------------------------------------------------------------
  // Edge detection on serial clock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sckD_r <= 1'b0;
    end else begin
      sckD_r <= bus.sck;
    end
  end

  // ----------------------------------------------------------------
  // Frame phase sequencing on rising edges
  // ----------------------------------------------------------------
  // Select high returns to command phase; a partial frame is discarded
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SFR_D_CMD;
      bitCnt_r <= 6'h0;
      op_r <= 8'h00;
      lanes_r <= sfr_pkg::SFR_LANE_ONE;
    end else if (bus.csN) begin
      state_r <= SFR_D_CMD;
      bitCnt_r <= 6'h0;
    end else if (rise) begin
      bitCnt_r <= bitCnt_r + 6'h1;
      unique case (state_r)
        SFR_D_CMD: begin
          op_r <= opNxt;  // MSB first
          if (bitCnt_r == sfr_pkg::CMD_BITS - 6'h1) begin
            bitCnt_r <= 6'h0;
            lanes_r <= (opNxt == sfr_pkg::OP_READ_QUAD) ? sfr_pkg::SFR_LANE_FOUR :
                       (opNxt == sfr_pkg::OP_READ_DUAL) ? sfr_pkg::SFR_LANE_TWO :
                       sfr_pkg::SFR_LANE_ONE;
            // Unknown opcodes and quad without enable park in the data phase
            if (opNxt == sfr_pkg::OP_READ_SLOW || opNxt == sfr_pkg::OP_READ_FAST ||
                opNxt == sfr_pkg::OP_READ_DUAL ||
                (opNxt == sfr_pkg::OP_READ_QUAD && quadEnable)) begin
              state_r <= SFR_D_ADDR;
            end else begin
              state_r <= SFR_D_DATA;
            end
          end
        end
        SFR_D_ADDR: begin
          if (bitCnt_r == sfr_pkg::ADDR_BITS - 6'h1) begin
            bitCnt_r <= 6'h0;
            // Slow read has no dummy byte
            state_r <= (op_r == sfr_pkg::OP_READ_SLOW) ? SFR_D_DATA : SFR_D_DUMMY;
          end
        end
        SFR_D_DUMMY: begin
          if (bitCnt_r == sfr_pkg::DUMMY_BITS - 6'h1) begin
            bitCnt_r <= 6'h0;
            state_r <= SFR_D_DATA;  // One dummy byte
          end
        end
        SFR_D_DATA: bitCnt_r <= 6'h0;
      endcase
    end
  end

  // Valid read flag: set on the first address rise after an accepted opcode
  // Rejected opcodes jump straight to data phase and leave it low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      valid_r <= 1'b0;
    end else if (bus.csN || state_r == SFR_D_CMD) begin
      valid_r <= 1'b0;
    end else if (rise && state_r != SFR_D_DATA) begin
      valid_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  // Shifted in on rises during the address, stepped on each byte's first slot
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= 24'h0;
    end else if (!bus.csN && rise && state_r == SFR_D_ADDR) begin
      addr_r <= {addr_r[22:0], bus.lane[0]};  // A23 first
    end else if (!bus.csN && fall && state_r == SFR_D_DATA && valid_r &&
                 slot_r == 3'h0) begin
      addr_r <= sfr_next_addr(addr_r);  // Byte latched, move on
    end
  end

  // ----------------------------------------------------------------
  // Output shifter, changes after falling edges
  // ----------------------------------------------------------------
  // Byte is latched from the array as its first slot goes out, so the
  // next address is fetched during the current byte: no wrap bubble.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slot_r <= 3'h0;
      outByte_r <= 8'h00;
      out_r <= 4'h0;
      oe_r <= 4'h0;
    end else if (bus.csN || state_r != SFR_D_DATA || !valid_r) begin
      slot_r <= 3'h0;
      out_r <= 4'h0;
      oe_r <= 4'h0;
    end else if (fall) begin
      oe_r <= sfr_lane_oe(lanes_r);
      if (slot_r == 3'h0) begin
        outByte_r <= memData;
        out_r <= sfr_slot_bits(lanes_r, memData, 3'h0);
      end else begin
        out_r <= sfr_slot_bits(lanes_r, outByte_r, slot_r);
      end
      slot_r <= (slot_r == lastSlot) ? 3'h0 : slot_r + 3'h1;
    end
  end
endmodule : sfr_dev
`default_nettype wire

// [tb/sfr_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Wire checks on the link where both ends are design code
module sfr_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic csN,
  input wire logic sck,
  input wire logic [3:0] hostOut,
  input wire logic [3:0] hostOe,
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOe,
  input wire logic [3:0] lane
);
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic sckPrev_r;
  logic [7:0] riseCnt_r;
  logic [7:0] opc_r;
  logic rise;
  // Same edge test as the device, so counts line up with its view
  assign rise = sck & ~sckPrev_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sckPrev_r <= 1'b0;
    end else begin
      sckPrev_r <= sck;
    end
  end
  // Rise count saturates so long reads never wrap back into the header
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      riseCnt_r <= 8'h00;
    end else if (csN) begin
      riseCnt_r <= 8'h00;
    end else if (rise && riseCnt_r != 8'hFF) begin
      riseCnt_r <= riseCnt_r + 8'h01;
    end
  end
  // Opcode as seen on the resolved serial in lane
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      opc_r <= 8'h00;
    end else if (csN) begin
      opc_r <= 8'h00;
    end else if (rise && riseCnt_r < 8'h08) begin
      opc_r <= {opc_r[6:0], lane[0]};
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_release_on_deselect: assert property (csN |-> devOe == 4'h0)
    else $error("device drives while deselected");
  chk_silent_in_header: assert property (riseCnt_r < 8'h20 |-> devOe == 4'h0)
    else $error("device drives during opcode or address");
  chk_dummy_before_data: assert property (devOe != 4'h0 && opc_r != sfr_pkg::OP_READ_SLOW
    |-> riseCnt_r >= 8'h28)
    else $error("data before the dummy byte ended");
  chk_slow_no_dummy: assert property (opc_r == sfr_pkg::OP_READ_SLOW && riseCnt_r == 8'h21
    && !csN |-> devOe == 4'h2)
    else $error("slow read data not right after address");
  chk_single_lane_only: assert property ((opc_r == sfr_pkg::OP_READ_SLOW
    || opc_r == sfr_pkg::OP_READ_FAST) |-> devOe inside {4'h0, 4'h2})
    else $error("single read drives a wrong lane");
  chk_dual_two_lanes: assert property (opc_r == sfr_pkg::OP_READ_DUAL && devOe != 4'h0
    |-> devOe == 4'h3)
    else $error("dual read lane enables wrong");
  chk_quad_four_lanes: assert property (opc_r == sfr_pkg::OP_READ_QUAD && devOe != 4'h0
    |-> devOe == 4'hF)
    else $error("quad read lane enables wrong");
  chk_dev_change_on_fall: assert property (sck && sckPrev_r && devOe != 4'h0
    |-> $stable(devOut))
    else $error("device output moved while clock high");
  chk_host_change_on_fall: assert property (sck && sckPrev_r && hostOe[0]
    |-> $stable(hostOut[0]))
    else $error("host bit moved while clock high");
  chk_no_lane_clash: assert property ((hostOe & devOe) == 4'h0)
    else $error("host and device drive one lane");
  cover property (devOe == 4'h2);
  cover property (devOe == 4'h3);
  cover property (devOe == 4'hF);
  cover property ($rose(csN) && $past(devOe) != 4'h0);
endmodule : sfr_monitor
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic quadEnable = 1'b1;
  logic [7:0] opcode = 8'h00;
  logic [23:0] startAddr = 24'h000000;
  logic busy, byteValid, reading;
  logic [7:0] byteData, memData, expByte;
  logic [23:0] memAddr;
  logic [7:0] expQ[$];
  int fails = 0;
  int num_checks = 0;
  int seen = 0;
  sfr_if bus ();
  always #2.5 core_clk = ~core_clk;
  // Array contents are a hash of the address so a wrong address shows
  function automatic logic [7:0] arr(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ {a[19:16], 4'hA};
  endfunction : arr
  assign memData = arr(memAddr);
  sfr_host i_sfr_host (.core_clk(core_clk), .resetn(resetn), .bus(bus), .start(start),
    .opcode(opcode), .startAddr(startAddr), .stop(stop), .busy(busy),
    .byteValid(byteValid), .byteData(byteData));
  sfr_dev i_sfr_dev (.core_clk(core_clk), .resetn(resetn), .bus(bus),
    .quadEnable(quadEnable), .memAddr(memAddr), .memData(memData), .reading(reading));
  sfr_monitor i_sfr_monitor (.core_clk(core_clk), .resetn(resetn), .csN(bus.csN),
    .sck(bus.sck), .hostOut(bus.hostOut), .hostOe(bus.hostOe), .devOut(bus.devOut),
    .devOe(bus.devOe), .lane(bus.lane));
  // Each strobed byte takes the oldest note; an empty queue never matches
  always @(negedge core_clk) begin
    if (resetn && byteValid === 1'b1) begin
      seen++;
      num_checks++;
      expByte = (expQ.size() != 0) ? expQ.pop_front() : 8'hXX;
      if (byteData !== expByte) begin
        fails++;
        $display("mismatch byteData expected %h seen %h", expByte, byteData);
      end
    end
  end
  // One frame of n bytes from a, stopped cut cycles after the last strobe
  task automatic readRun(input logic [7:0] op, input logic [23:0] a, input int n,
    input int cut, input logic ok);
    int k;
    k = 0;
    seen = 0;
    opcode = op;
    startAddr = a;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    for (int i = 0; i < n; i++) begin
      expQ.push_back(ok ? arr(a) : 8'hFF);
      a = (a == sfr_pkg::ARRAY_TOP) ? sfr_pkg::ARRAY_BASE : a + 24'h000001;
    end
    while (seen < n && k < 4000) begin
      @(negedge core_clk);
      k++;
    end
    num_checks++;
    if (busy !== 1'b1 || reading !== 1'b1) begin
      fails++;
      $display("mismatch busy_reading expected 11 seen %b%b", busy, reading);
    end
    repeat (cut) @(negedge core_clk);
    stop = 1'b1;
    @(negedge core_clk);
    stop = 1'b0;
    repeat (3) @(negedge core_clk);
    num_checks++;
    if (expQ.size() != 0 || k >= 4000) begin
      fails++;
      $display("mismatch pending expected 0 seen %0d", expQ.size());
      expQ.delete();
    end
    num_checks++;
    if (busy !== 1'b0 || reading !== 1'b0) begin
      fails++;
      $display("mismatch idle_after_stop expected 00 seen %b%b", busy, reading);
    end
  endtask : readRun
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] ops [4];
    ops = '{sfr_pkg::OP_READ_SLOW, sfr_pkg::OP_READ_FAST, sfr_pkg::OP_READ_DUAL,
      sfr_pkg::OP_READ_QUAD};
    void'($urandom(32'h5E58298C));
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    foreach (ops[i]) begin
      readRun(ops[i], 24'($urandom) & 24'h07FFFF, $urandom_range(1, 4), 0, 1'b1);
      readRun(ops[i], sfr_pkg::ARRAY_TOP - 24'h000001, 3, 7, 1'b1);
    end
    // Without the enable the quad read is refused and the lanes float high
    quadEnable = 1'b0;
    readRun(sfr_pkg::OP_READ_QUAD, 24'h000100, 2, 0, 1'b0);
    quadEnable = 1'b1;
    // An unknown opcode parks the device the same way
    readRun(8'hC3, 24'h000200, 1, 0, 1'b0);
    tally_and_finish();
  end
  // Hang guard, far above the few thousand cycles the frames need
  initial begin
    #200000;
    fails++;
    $display("mismatch watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
